// >>> hdl/pfsw_timer.sv
// pfsw_timer: self-timed busy counter for program and erase
// assumes: start is a one-cycle pulse while idle
`timescale 1ns/100ps
module pfsw_timer #(
    parameter int CW = 8
) (
    input  wire logic          clock_in,
    input  wire logic          rst_in,
    input  wire logic          start_in,
    input  wire logic [CW-1:0] length_in,
    output logic               busy_out,
    output logic               done_out
);
    logic [CW-1:0] count_q;
    logic          busy_q;
    logic          done_q;
    wire           last = busy_q && (count_q == '0);

    // count down from length, pulse done at the end
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            count_q <= '0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            done_q <= last;
            if (start_in && !busy_q) begin
                count_q <= length_in;
                busy_q  <= 1'b1;
            end else if (last) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;
endmodule

// >>> hdl/pfsw_top.sv
// pfsw_top: flash self-write control with apb register access
// assumes: array memory held inside; apb master per amba rules
`timescale 1ns/100ps
module pfsw_top
    import pfsw_pkg::*;
#(
    parameter int DEPTH = 1 << pfsw_pkg::PFSW_ADDR_W
) (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             busy_out
);
    import pfsw_pkg::*;

    // ************************************************************
    // bus decode
    // ************************************************************
    pfsw_apb_req_t req;
    assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                   paddr: paddr_in, pwdata: pwdata_in};

    logic       pready_q;
    wire        access  = req.psel && req.penable && !pready_q;
    wire        wr_acc  = access && req.pwrite;
    wire        sel_ctl = req.paddr == PFSW_OFF_CONTROL;
    wire        sel_ulk = req.paddr == PFSW_OFF_UNLOCK;
    wire        sel_al  = req.paddr == PFSW_OFF_ADDR_LOW;
    wire        sel_ah  = req.paddr == PFSW_OFF_ADDR_HIGH;
    wire        sel_dl  = req.paddr == PFSW_OFF_DATA_LOW;
    wire        sel_dh  = req.paddr == PFSW_OFF_DATA_HIGH;
    wire        mapped  = sel_ctl | sel_ulk | sel_al | sel_ah | sel_dl | sel_dh;
    wire [7:0]  wbyte   = req.pwdata[7:0];

    // ************************************************************
    // register state
    // ************************************************************
    logic                   cfg_sel_q;
    logic                   latch_only_q;
    logic                   erase_sel_q;
    logic                   fault_q;
    logic                   modify_en_q;
    logic                   prog_start_q;
    logic                   read_start_q;
    logic [PFSW_ADDR_W-1:0] addr_q;
    logic [PFSW_WORD_W-1:0] data_q;
    logic                   op_erase_q;
    logic [2:0]             win_q;
    pfsw_unlock_t           ul_q;
    pfsw_unlock_t           ul_d;
    logic [PFSW_WORD_W-1:0] mem [DEPTH];
    logic [31:0]            prdata_q;
    logic                   pslverr_q;
    logic                   busy_q;

    // ************************************************************
    // unlock sequence and start conditions
    // ************************************************************
    wire ulk_wr   = wr_acc && sel_ulk;
    wire ctl_wr   = wr_acc && sel_ctl;
    wire win_out  = win_q == 3'(PFSW_UNLOCK_WIN - 1);
    wire tmr_busy;
    wire tmr_done;
    // start only when armed, enabled and idle
    wire want_go  = ctl_wr && wbyte[PFSW_BIT_PROG_START];
    wire go       = want_go && (ul_q == PFSW_UL_ARMED)
                    && modify_en_q && !prog_start_q;
    wire rd_go    = ctl_wr && wbyte[PFSW_BIT_READ_START] && !prog_start_q;
    wire go_erase = wbyte[PFSW_BIT_ERASE_SEL];
    // latch-only start runs no timer but still sets fault; erase ignores it
    wire go_latch = wbyte[PFSW_BIT_LATCH_ONLY] && !go_erase;
    wire [7:0] len = go_erase ? 8'(PFSW_ERASE_CYC) : 8'(PFSW_WRITE_CYC);

    // unlock pattern tracker; written values are never stored
    always_comb begin
        ul_d = ul_q;
        unique case (ul_q)
            PFSW_UL_IDLE:
                if (ulk_wr && wbyte == PFSW_UNLOCK_1) ul_d = PFSW_UL_GOT1;
            PFSW_UL_GOT1:
                if (ulk_wr) begin
                    ul_d = (wbyte == PFSW_UNLOCK_2) ? PFSW_UL_ARMED
                                                    : PFSW_UL_IDLE;
                end else if (wr_acc || win_out) begin
                    ul_d = PFSW_UL_IDLE;
                end
            PFSW_UL_ARMED:
                if (wr_acc || win_out) ul_d = PFSW_UL_IDLE;
            default: ul_d = PFSW_UL_IDLE;
        endcase
    end

    // unlock state and its time window
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ul_q  <= PFSW_UL_IDLE;
            win_q <= '0;
        end else begin
            ul_q  <= ul_d;
            win_q <= (ul_d != ul_q || ul_d == PFSW_UL_IDLE) ? '0
                                                            : win_q + 1'b1;
        end
    end

    // ************************************************************
    // self-timed operation
    // ************************************************************
    pfsw_timer #(
        .CW (8)
    ) u_timer (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .start_in  (go && !go_latch),
        .length_in (len),
        .busy_out  (tmr_busy),
        .done_out  (tmr_done)
    );

    // array request, erase covers the aligned row
    pfsw_array_req_t arr;
    assign arr = '{wr: tmr_done && !op_erase_q, erase: tmr_done && op_erase_q,
                   addr: addr_q, data: data_q};

    // flash array: write on completion, row erase sets all ones
    always_ff @(posedge clock_in) begin
        if (arr.wr) begin
            mem[arr.addr] <= arr.data;
        end
        if (arr.erase) begin
            for (int i = 0; i < PFSW_ROW_WORDS; i++) begin
                mem[{arr.addr[PFSW_ADDR_W-1:5], 5'(i)}] <= '1;
            end
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cfg_sel_q    <= 1'b0;
            latch_only_q <= 1'b0;
            erase_sel_q  <= 1'b0;
            fault_q      <= 1'b0;
            modify_en_q  <= 1'b0;
            prog_start_q <= 1'b0;
            read_start_q <= 1'b0;
            op_erase_q   <= 1'b0;
        end else begin
            if (ctl_wr) begin
                cfg_sel_q    <= wbyte[PFSW_BIT_CFG_SEL];
                latch_only_q <= wbyte[PFSW_BIT_LATCH_ONLY];
                modify_en_q  <= wbyte[PFSW_BIT_MODIFY_EN];
                if (!prog_start_q) begin
                    erase_sel_q <= wbyte[PFSW_BIT_ERASE_SEL];
                end
                fault_q      <= wbyte[PFSW_BIT_FAULT];
            end
            // software only sets; zero writes ignored
            if (go) begin
                prog_start_q <= !go_latch;
                op_erase_q   <= go_erase;
                fault_q      <= 1'b1;
            end else if (want_go && !modify_en_q) begin
                prog_start_q <= prog_start_q;
            end
            if (tmr_done) begin
                prog_start_q <= 1'b0;
                fault_q      <= 1'b0;
                if (op_erase_q) erase_sel_q <= 1'b0;
            end
            // read takes one cycle then clears
            read_start_q <= rd_go;
        end
    end

    // ************************************************************
    // address and data registers
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            addr_q <= '0;
            data_q <= '0;
        end else begin
            if (wr_acc && sel_al) addr_q[7:0]  <= wbyte;
            if (wr_acc && sel_ah) addr_q[14:8] <= wbyte[6:0];
            if (wr_acc && sel_dl) data_q[7:0]  <= wbyte;
            if (wr_acc && sel_dh) data_q[13:8] <= wbyte[5:0];
            if (read_start_q) data_q <= mem[addr_q];
        end
    end

    // ************************************************************
    // read mux and bus answer
    // ************************************************************
    wire [7:0] ctl_rd = {1'b1, cfg_sel_q, latch_only_q, erase_sel_q,
                         fault_q, modify_en_q, prog_start_q,
                         read_start_q};
    wire [7:0] rd_byte =
        sel_ctl ? ctl_rd :
        sel_al  ? addr_q[7:0] :
        sel_ah  ? {1'b1, addr_q[14:8]} :
        sel_dl  ? data_q[7:0] :
        sel_dh  ? {2'b00, data_q[13:8]} :
        8'h00;                                  // unlock reads zero

    // one wait state: pready in second access cycle
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            pready_q  <= access;
            prdata_q  <= access ? {24'h000000, rd_byte} : 32'h00000000;
            pslverr_q <= access && !mapped;
            busy_q    <= tmr_busy;
        end
    end

    assign prdata_out  = prdata_q;
    assign pready_out  = pready_q;
    assign pslverr_out = pslverr_q;
    assign busy_out    = busy_q;
endmodule

// >>> include/pfsw_pkg.sv
// pfsw_pkg: constants and types for the flash self-write controller
// assumes: 40 MHz core clock, apb slave with 32-bit data, word aligned
//
// Function
// - latch-only setting ignored during erase
// - starting program/erase sets the fault flag
// - program-start bit set by software only
// - program-start clears when operation finishes
// - unlock accepted only in tight sequence
// - unlock register write-only, resets to zero
// - data-high upper two bits read zero
// - address is fifteen bits, high then low
// - flash word fourteen bits, high then low
package pfsw_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] PFSW_OFF_CONTROL   = 8'h00;
    localparam logic [7:0] PFSW_OFF_UNLOCK    = 8'h04;
    localparam logic [7:0] PFSW_OFF_ADDR_LOW  = 8'h08;
    localparam logic [7:0] PFSW_OFF_ADDR_HIGH = 8'h0c;
    localparam logic [7:0] PFSW_OFF_DATA_LOW  = 8'h10;
    localparam logic [7:0] PFSW_OFF_DATA_HIGH = 8'h14;

    // ************************************************************
    // control register field positions
    // ************************************************************
    localparam int PFSW_BIT_READ_START  = 0;
    localparam int PFSW_BIT_PROG_START  = 1;
    localparam int PFSW_BIT_MODIFY_EN   = 2;
    localparam int PFSW_BIT_FAULT       = 3;
    localparam int PFSW_BIT_ERASE_SEL   = 4;
    localparam int PFSW_BIT_LATCH_ONLY  = 5;
    localparam int PFSW_BIT_CFG_SEL     = 6;

    // ************************************************************
    // widths, patterns, reset values
    // ************************************************************
    localparam int         PFSW_ADDR_W      = 15;
    localparam int         PFSW_WORD_W      = 14;
    localparam logic [7:0] PFSW_UNLOCK_1    = 8'h55;
    localparam logic [7:0] PFSW_UNLOCK_2    = 8'haa;
    localparam logic [7:0] PFSW_UNLOCK_RST  = 8'h00;
    localparam logic [7:0] PFSW_CTRL_RST    = 8'h00;
    localparam int         PFSW_UNLOCK_WIN  = 8;

    // ************************************************************
    // self-timed operation lengths
    // ************************************************************
    localparam int PFSW_CLK_MHZ      = 40;
    localparam int PFSW_WRITE_US     = 2;
    localparam int PFSW_ERASE_US     = 2;
    localparam int PFSW_WRITE_CYC    = PFSW_WRITE_US * PFSW_CLK_MHZ;
    localparam int PFSW_ERASE_CYC    = PFSW_ERASE_US * PFSW_CLK_MHZ;
    localparam int PFSW_ROW_WORDS    = 32;

    // unlock sequence states
    typedef enum logic [2:0] {
        PFSW_UL_IDLE  = 3'b001,
        PFSW_UL_GOT1  = 3'b010,
        PFSW_UL_ARMED = 3'b100
    } pfsw_unlock_t;

    // apb request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pfsw_apb_req_t;

    // flash array port bundle
    typedef struct packed {
        logic                   wr;
        logic                   erase;
        logic [PFSW_ADDR_W-1:0] addr;
        logic [PFSW_WORD_W-1:0] data;
    } pfsw_array_req_t;

endpackage

// >>> tb/pfsw_properties.sv
// pfsw_properties: port-level checks for the flash self-write block
// assumes: bound to pfsw_top, apb master with one request at a time
`timescale 1ns/100ps
module pfsw_properties
    import pfsw_pkg::*;
#(
    parameter int DEPTH = 1 << pfsw_pkg::PFSW_ADDR_W
) (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        busy_out
);
    // ************************************************************
    // helper decode and busy length counter
    // ************************************************************
    localparam int BUSY_MAX = PFSW_ERASE_CYC + 4;
    logic [7:0] busy_cnt_q;
    logic [7:0] busy_cnt_d;
    wire take_rd  = psel_in && penable_in && !pwrite_in && !pready_out;
    wire unmapped = (paddr_in > PFSW_OFF_DATA_HIGH)
                    || (paddr_in[1:0] != 2'b00);
    assign busy_cnt_d = busy_out ? busy_cnt_q + 8'h01 : 8'h00;
    // count consecutive busy cycles
    always_ff @(posedge clock_in) begin
        busy_cnt_q <= rst_in ? 8'h00 : busy_cnt_d;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_ready_one_wait: assert property (
        psel_in && penable_in && !pready_out |=> pready_out)
        else $error("pready missing after access cycle");
    a_ready_single: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_ready_has_req: assert property (
        pready_out |-> $past(psel_in && penable_in))
        else $error("pready without request");
    a_err_on_unmapped: assert property (
        pready_out |-> pslverr_out == $past(unmapped))
        else $error("pslverr does not match address map");
    a_ctrl_msb_one: assert property (
        pready_out && $past(take_rd && paddr_in == PFSW_OFF_CONTROL)
        |-> prdata_out[7])
        else $error("control msb not one");
    a_addrh_msb_one: assert property (
        pready_out && $past(take_rd && paddr_in == PFSW_OFF_ADDR_HIGH)
        |-> prdata_out[7])
        else $error("address high msb not one");
    a_datah_top_zero: assert property (
        pready_out && $past(take_rd && paddr_in == PFSW_OFF_DATA_HIGH)
        |-> prdata_out[7:6] == 2'b00)
        else $error("data high top bits not zero");
    a_unlock_reads_zero: assert property (
        pready_out && $past(take_rd && paddr_in == PFSW_OFF_UNLOCK)
        |-> prdata_out == 32'h00000000)
        else $error("unlock register read not zero");
    a_busy_bounded: assert property (busy_cnt_q <= BUSY_MAX)
        else $error("operation did not finish in time");
endmodule

bind pfsw_top pfsw_properties #(.DEPTH(DEPTH)) u_pfsw_props (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .busy_out    (busy_out)
);

// >>> tb/tb_top.sv
// tb_top: self-checking bench for the flash self-write block
// assumes: pfsw_top with apb slave, one wait state, 40 mhz clock
`timescale 1ns/100ps
module tb_top;
    import pfsw_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_in   = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    int          error_cnt    = 0;
    int          total_checks = 0;
    int          cycle_cnt    = 0;

    pfsw_top dut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .busy_out(busy));

    // ************************************************************
    // clock, watchdog, bus and compare tasks
    // ************************************************************
    always #12.5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycle_cnt++;
        if (cycle_cnt == 5000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge clock_in);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clock_in);
        penable <= 1'b1;
        n = 0;
        @(posedge clock_in);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clock_in);
            n++;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, n < 50}, 32'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, exp);
    endtask
    task automatic unlock();
        wr(PFSW_OFF_UNLOCK, PFSW_UNLOCK_1);
        wr(PFSW_OFF_UNLOCK, PFSW_UNLOCK_2);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy === 1'b1 && n < 300) begin
            @(posedge clock_in);
            n++;
        end
        chk({31'h0, busy}, 32'h0);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_vals();
        rd_chk(PFSW_OFF_CONTROL, 32'h80);
        rd_chk(PFSW_OFF_ADDR_HIGH, 32'h80);
        rd_chk(PFSW_OFF_ADDR_LOW, 32'h00);
        rd_chk(PFSW_OFF_UNLOCK, 32'h00);
    endtask
    task automatic t_unmapped();
        logic [31:0] r;
        logic        e;
        apb(1'b0, 8'h18, 8'h00, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h02, 8'hff, r, e);
        chk({31'h0, e}, 32'h1);
        rd_chk(PFSW_OFF_CONTROL, 32'h80);
    endtask
    task automatic t_fields();
        wr(PFSW_OFF_ADDR_HIGH, 8'hff);
        rd_chk(PFSW_OFF_ADDR_HIGH, 32'hff);
        wr(PFSW_OFF_ADDR_HIGH, 8'h00);
        rd_chk(PFSW_OFF_ADDR_HIGH, 32'h80);
        wr(PFSW_OFF_DATA_HIGH, 8'hff);
        rd_chk(PFSW_OFF_DATA_HIGH, 32'h3f);
        wr(PFSW_OFF_ADDR_LOW, 8'ha5);
        rd_chk(PFSW_OFF_ADDR_LOW, 32'ha5);
    endtask
    task automatic t_refused();
        wr(PFSW_OFF_CONTROL, 8'h06);
        rd_chk(PFSW_OFF_CONTROL, 32'h84);
        // enable is the stored bit, so clear it before the armed start
        wr(PFSW_OFF_CONTROL, 8'h00);
        unlock();
        wr(PFSW_OFF_CONTROL, 8'h02);
        rd_chk(PFSW_OFF_CONTROL, 32'h80);
        chk({31'h0, busy}, 32'h0);
        rd_chk(PFSW_OFF_UNLOCK, 32'h00);
        // enable first, so only a broken or timed-out unlock sequence refuses the start
        wr(PFSW_OFF_CONTROL, 8'h04);
        wr(PFSW_OFF_UNLOCK, PFSW_UNLOCK_1);
        wr(PFSW_OFF_ADDR_LOW, 8'h23);
        wr(PFSW_OFF_UNLOCK, PFSW_UNLOCK_2);
        wr(PFSW_OFF_CONTROL, 8'h06);
        rd_chk(PFSW_OFF_CONTROL, 32'h84);
        unlock();
        repeat (12) @(posedge clock_in);
        wr(PFSW_OFF_CONTROL, 8'h06);
        rd_chk(PFSW_OFF_CONTROL, 32'h84);
        chk({31'h0, busy}, 32'h0);
    endtask
    task automatic t_program();
        wr(PFSW_OFF_ADDR_HIGH, 8'h01);
        wr(PFSW_OFF_ADDR_LOW, 8'h23);
        wr(PFSW_OFF_DATA_HIGH, 8'h2a);
        wr(PFSW_OFF_DATA_LOW, 8'hbc);
        unlock();
        wr(PFSW_OFF_CONTROL, 8'h06);
        rd_chk(PFSW_OFF_CONTROL, 32'h8e);
        chk({31'h0, busy}, 32'h1);
        wr(PFSW_OFF_CONTROL, 8'h0c);
        rd_chk(PFSW_OFF_CONTROL, 32'h8e);
        wait_idle();
        rd_chk(PFSW_OFF_CONTROL, 32'h84);
        wr(PFSW_OFF_DATA_LOW, 8'h00);
        wr(PFSW_OFF_DATA_HIGH, 8'h00);
        wr(PFSW_OFF_CONTROL, 8'h05);
        rd_chk(PFSW_OFF_CONTROL, 32'h84);
        rd_chk(PFSW_OFF_DATA_LOW, 32'hbc);
        rd_chk(PFSW_OFF_DATA_HIGH, 32'h2a);
    endtask
    task automatic t_erase();
        // latch-only start loads nothing timed, yet flags the attempt
        unlock();
        wr(PFSW_OFF_CONTROL, 8'h26);
        rd_chk(PFSW_OFF_CONTROL, 32'hac);
        chk({31'h0, busy}, 32'h0);
        unlock();
        wr(PFSW_OFF_CONTROL, 8'h36);
        rd_chk(PFSW_OFF_CONTROL, 32'hbe);
        wait_idle();
        rd_chk(PFSW_OFF_CONTROL, 32'ha4);
        wr(PFSW_OFF_ADDR_LOW, 8'h3f);
        wr(PFSW_OFF_CONTROL, 8'h05);
        rd_chk(PFSW_OFF_DATA_LOW, 32'hff);
        rd_chk(PFSW_OFF_DATA_HIGH, 32'h3f);
    endtask
    // reset in mid operation drops busy and returns control to its reset value
    task automatic t_reset_mid();
        unlock();
        wr(PFSW_OFF_CONTROL, 8'h06);
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        chk({31'h0, busy}, 32'h0);
        rd_chk(PFSW_OFF_CONTROL, 32'h80);
        wr(PFSW_OFF_CONTROL, 8'h04);
        wr(PFSW_OFF_CONTROL, 8'h06);
        rd_chk(PFSW_OFF_CONTROL, 32'h84);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset_vals();
        t_unmapped();
        t_fields();
        t_refused();
        t_program();
        t_erase();
        t_reset_mid();
        finish_test();
    end
endmodule
